// ### core/dmj_debug_port.sv
`timescale 1ns/1ps
// Summary of operation
// - instruction codes 0x8 to 0xB route the serial path to debug.
// - comm byte register at i/o 0x31, eight bits, zero after reset.
// - cpu write to comm byte sets the dirty flag.
// - cpu read returns seven low bits plus dirty flag in bit seven.
// - comm byte reached only with debug fuse and debugger access enabled.
// - mcu control bit seven disables the port; zero enables with fuse.
// - port-disable bit changes only on equal double write within four cycles.
// - port works on four pins, needs enable fuse and cleared disable bit.
// - serial programming covers flash, eeprom, fuses and lock bits.
// - lock bits block programming the debug fuse until chip erase.
// - debug system needs both fuses and no memory lock bit.
// - four-bit instructions shift lsb first, capture value 0x01 out.
module dmj_debug_port
  import dmj_pkg::*;
(
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  input  wire dmj_cpu_req_s i_cpu,
  input  wire dmj_fuse_s    i_fuse,
  input  wire logic [7:0]   i_std_io_rdata,
  input  wire logic         i_chip_erased,
  output logic [7:0]        o_cpu_rdata,
  output logic              o_std_io_sel,
  output logic              o_port_disable,
  output logic              o_prog_active,
  output logic              o_debug_fuse_wr_ok,
  input  wire logic         i_tck,
  input  wire logic         i_tms,
  input  wire logic         i_tdi,
  output logic              o_tdo,
  output logic              o_tdo_oe_n,
  output logic [3:0]        o_instr,
  output logic              o_debug_sel
);

  dmj_cpu_st_s c;
  dmj_cpu_st_s next_c;
  dmj_tck_st_s t;
  dmj_tck_st_s next_t;

  logic debug_ok;
  logic port_ok;
  logic comm_hit;
  logic ctrl_hit;
  logic dbg_instr;

  assign debug_ok = i_fuse.port_enable_fuse & i_fuse.debug_enable_fuse
                  & ~i_fuse.memory_lock_a & ~i_fuse.memory_lock_b;
  assign port_ok  = i_fuse.port_enable_fuse & ~c.ctrl[DMJ_PORT_DIS_BIT];
  assign comm_hit  = (i_cpu.addr == DMJ_COMM_IO_ADDR) & debug_ok & c.acc_sync[1];
  assign ctrl_hit  = (i_cpu.addr == DMJ_CTRL_IO_ADDR);

  always_comb
  begin
    next_c = c;
    next_c.clr_sync = {c.clr_sync[0], t.clr_tgl};
    next_c.clr_seen = c.clr_sync[1];
    next_c.acc_sync = {c.acc_sync[0], t.acc_en};
    next_c.prog_sync = {c.prog_sync[0], t.ir == DMJ_INSTR_PROG};
    if (c.clr_sync[1] != c.clr_seen)
    begin
      next_c.dirty = 1'b0;
    end
    if (c.win_cnt != 3'h0)
    begin
      next_c.win_cnt = c.win_cnt - 3'h1;
    end
    next_c.rd_hit = 1'b0;
    if (i_cpu.wr & comm_hit)
    begin
      next_c.comm = i_cpu.wdata;
      // write sets dirty, set beats clear
      next_c.dirty = 1'b1;
    end
    else if (i_cpu.wr & ctrl_hit)
    begin
      next_c.ctrl[6:0] = i_cpu.wdata[6:0];
      if ((c.win_cnt != 3'h0) && (c.win_val == i_cpu.wdata[DMJ_PORT_DIS_BIT]))
      begin
        next_c.ctrl[DMJ_PORT_DIS_BIT] = i_cpu.wdata[DMJ_PORT_DIS_BIT];
        next_c.win_cnt = 3'h0;
      end
      else
      begin
        next_c.win_val = i_cpu.wdata[DMJ_PORT_DIS_BIT];
        next_c.win_cnt = 3'(DMJ_TIMED_CYCLES);
      end
    end
    if (i_cpu.rd)
    begin
      if (comm_hit)
      begin
        next_c.rdata = {c.dirty, c.comm[6:0]};
      end
      else if (ctrl_hit)
      begin
        next_c.rdata = c.ctrl;
      end
      else
      begin
        next_c.rdata = 8'h00;
        next_c.rd_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      c <= '{comm: DMJ_COMM_RESET, ctrl: DMJ_CTRL_RESET, default: '0};
    end
    else if (i_ce)
    begin
      c <= next_c;
    end
  end

  // std io data passes through when the debug register is not selected
  assign o_cpu_rdata    = c.rd_hit ? i_std_io_rdata : c.rdata;
  assign o_std_io_sel   = ~comm_hit & ~ctrl_hit;
  assign o_port_disable = c.ctrl[DMJ_PORT_DIS_BIT];
  assign o_prog_active  = c.prog_sync[1] & port_ok;
  assign o_debug_fuse_wr_ok = i_chip_erased
                            | ~(i_fuse.memory_lock_a | i_fuse.memory_lock_b);

  // link side; port disable and dirty flag cross as levels, the comm byte as sampled words
  // debug instruction decode
  assign dbg_instr = (t.ir == DMJ_INSTR_A) | (t.ir == DMJ_INSTR_B)
                   | (t.ir == DMJ_INSTR_C) | (t.ir == DMJ_INSTR_D);

  always_comb
  begin
    next_t = t;
    next_t.en_sync    = {t.en_sync[0], port_ok};
    next_t.dirty_sync = {t.dirty_sync[0], c.dirty};
    next_t.comm_sync  = {t.comm_sync[7:0], c.comm};
    next_t.tdo_oe_n   = 1'b1;
    case (t.tap)
      DMJ_TLR:    next_t.tap = i_tms ? DMJ_TLR : DMJ_RTI;
      DMJ_RTI:    next_t.tap = i_tms ? DMJ_SEL_DR : DMJ_RTI;
      DMJ_SEL_DR: next_t.tap = i_tms ? DMJ_SEL_IR : DMJ_CAP_DR;
      DMJ_CAP_DR: next_t.tap = i_tms ? DMJ_EX1_DR : DMJ_SH_DR;
      DMJ_SH_DR:  next_t.tap = i_tms ? DMJ_EX1_DR : DMJ_SH_DR;
      DMJ_EX1_DR: next_t.tap = i_tms ? DMJ_UP_DR : DMJ_PA_DR;
      DMJ_PA_DR:  next_t.tap = i_tms ? DMJ_EX2_DR : DMJ_PA_DR;
      DMJ_EX2_DR: next_t.tap = i_tms ? DMJ_UP_DR : DMJ_SH_DR;
      DMJ_UP_DR:  next_t.tap = i_tms ? DMJ_SEL_DR : DMJ_RTI;
      DMJ_SEL_IR: next_t.tap = i_tms ? DMJ_TLR : DMJ_CAP_IR;
      DMJ_CAP_IR: next_t.tap = i_tms ? DMJ_EX1_IR : DMJ_SH_IR;
      DMJ_SH_IR:  next_t.tap = i_tms ? DMJ_EX1_IR : DMJ_SH_IR;
      DMJ_EX1_IR: next_t.tap = i_tms ? DMJ_UP_IR : DMJ_PA_IR;
      DMJ_PA_IR:  next_t.tap = i_tms ? DMJ_EX2_IR : DMJ_PA_IR;
      DMJ_EX2_IR: next_t.tap = i_tms ? DMJ_UP_IR : DMJ_SH_IR;
      DMJ_UP_IR:  next_t.tap = i_tms ? DMJ_SEL_DR : DMJ_RTI;
      default:    next_t.tap = DMJ_TLR;
    endcase
    case (t.tap)
      DMJ_TLR:
      begin
        next_t.ir = DMJ_IR_RESET;
        next_t.acc_en = 1'b0;
      end
      DMJ_CAP_IR: next_t.ir_sh = DMJ_IR_CAPTURE;
      DMJ_SH_IR:
      begin
        next_t.ir_sh = {i_tdi, t.ir_sh[3:1]};
        next_t.tdo = t.ir_sh[0];
        next_t.tdo_oe_n = 1'b0;
      end
      DMJ_UP_IR:  next_t.ir = t.ir_sh;
      DMJ_CAP_DR:
      begin
        next_t.dr_sh = dbg_instr ? {t.dirty_sync[1], t.comm_sync[15:8]} : 9'h000;
      end
      DMJ_SH_DR:
      begin
        next_t.dr_sh = {i_tdi, t.dr_sh[8:1]};
        next_t.tdo = t.dr_sh[0];
        next_t.tdo_oe_n = 1'b0;
      end
      DMJ_UP_DR:
      begin
        if (dbg_instr)
        begin
          // debugger clears dirty; bit0 of update enables access
          if (t.dr_sh[8])
          begin
            next_t.clr_tgl = ~t.clr_tgl;
          end
          next_t.acc_en = t.dr_sh[0];
        end
      end
      default: next_t.tdo = t.tdo;
    endcase
    // port gated by fuse and disable bit
    if (!t.en_sync[1])
    begin
      next_t.tap = DMJ_TLR;
      next_t.ir = DMJ_IR_RESET;
      next_t.tdo_oe_n = 1'b1;
    end
  end

  always_ff @(posedge i_tck)
  begin
    if (i_rst)
    begin
      t <= '{tap: DMJ_TLR, ir: DMJ_IR_RESET, tdo_oe_n: 1'b1, default: '0};
    end
    else
    begin
      t <= next_t;
    end
  end

  assign o_tdo       = t.tdo;
  assign o_tdo_oe_n  = t.tdo_oe_n;
  assign o_instr     = t.ir;
  assign o_debug_sel = dbg_instr & debug_ok;

endmodule

// ### core/dmj_pkg.sv
package dmj_pkg;

  // cpu i/o map
  localparam logic [5:0] DMJ_COMM_IO_ADDR   = 6'h31;
  localparam logic [7:0] DMJ_COMM_DATA_ADDR = 8'h51;
  localparam logic [5:0] DMJ_CTRL_IO_ADDR   = 6'h35;
  localparam int         DMJ_PORT_DIS_BIT   = 7;
  localparam logic [7:0] DMJ_COMM_RESET     = 8'h00;
  localparam logic [7:0] DMJ_CTRL_RESET     = 8'h00;
  localparam int         DMJ_TIMED_CYCLES   = 4;

  // tap instruction register
  localparam int         DMJ_IR_W           = 4;
  localparam logic [3:0] DMJ_IR_CAPTURE     = 4'h1;
  localparam logic [3:0] DMJ_IR_RESET       = 4'hf;
  localparam logic [3:0] DMJ_INSTR_A        = 4'h8;
  localparam logic [3:0] DMJ_INSTR_B        = 4'h9;
  localparam logic [3:0] DMJ_INSTR_C        = 4'ha;
  localparam logic [3:0] DMJ_INSTR_D        = 4'hb;
  localparam logic [3:0] DMJ_INSTR_PROG     = 4'h4;
  localparam int         DMJ_DR_W           = 9;

  typedef enum logic [3:0] {
    DMJ_TLR, DMJ_RTI, DMJ_SEL_DR, DMJ_CAP_DR, DMJ_SH_DR, DMJ_EX1_DR, DMJ_PA_DR,
    DMJ_EX2_DR, DMJ_UP_DR, DMJ_SEL_IR, DMJ_CAP_IR, DMJ_SH_IR, DMJ_EX1_IR,
    DMJ_PA_IR, DMJ_EX2_IR, DMJ_UP_IR
  } dmj_tap_e;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } dmj_cpu_req_s;

  typedef struct packed {
    logic port_enable_fuse;
    logic debug_enable_fuse;
    logic memory_lock_a;
    logic memory_lock_b;
  } dmj_fuse_s;

  // cpu clock domain state
  typedef struct packed {
    logic [7:0] comm;
    logic       dirty;
    logic [7:0] ctrl;
    logic [2:0] win_cnt;
    logic       win_val;
    logic [7:0] rdata;
    logic       rd_hit;
    logic [1:0] clr_sync;
    logic       clr_seen;
    logic [1:0] acc_sync;
    logic [1:0] prog_sync;
  } dmj_cpu_st_s;

  // link clock domain state
  typedef struct packed {
    dmj_tap_e          tap;
    logic [3:0]        ir_sh;
    logic [3:0]        ir;
    logic [8:0]        dr_sh;
    logic              tdo;
    logic              tdo_oe_n;
    logic              clr_tgl;
    logic              acc_en;
    logic [1:0]        dirty_sync;
    logic [1:0]        en_sync;
    logic [15:0]       comm_sync;
  } dmj_tck_st_s;

endpackage

// ### verif/dmj_checker.sv
`timescale 1ns/1ps
module dmj_checker
  import dmj_pkg::*;
(
  input wire logic         i_mclk,
  input wire logic         i_rst,
  input wire logic         i_ce,
  input wire dmj_cpu_req_s i_cpu,
  input wire dmj_fuse_s    i_fuse,
  input wire logic         i_chip_erased,
  input wire logic [7:0]   o_cpu_rdata,
  input wire logic         o_std_io_sel,
  input wire logic         o_port_disable,
  input wire logic         o_debug_fuse_wr_ok,
  input wire logic [3:0]   o_instr,
  input wire logic         o_debug_sel
);
  wire logic acc = i_ce && (i_cpu.rd || i_cpu.wr) && i_cpu.addr == DMJ_COMM_IO_ADDR;
  wire logic wr = acc && i_cpu.wr && !o_std_io_sel;
  wire logic rd = acc && i_cpu.rd && !o_std_io_sel;
  wire logic ctl = i_ce && i_cpu.wr && i_cpu.addr == DMJ_CTRL_IO_ADDR;
  wire logic wb = i_cpu.wdata[DMJ_PORT_DIS_BIT];
  wire logic lk = i_fuse.memory_lock_a || i_fuse.memory_lock_b;
  logic [7:0] wd_q;
  // no reset needed: only read after a write
  always_ff @(posedge i_mclk) if (wr) wd_q <= i_cpu.wdata;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  chk_wr_dirty: assert property (wr ##1 !wr ##1 rd |=> o_cpu_rdata == {1'b1, wd_q[6:0]})
    else $error("bad mailbox readback");
  chk_no_fuse: assert property (acc && !i_fuse.debug_enable_fuse |-> o_std_io_sel)
    else $error("mailbox open without fuse");
  chk_lock_std: assert property (acc && lk |-> o_std_io_sel)
    else $error("mailbox open while locked");
  chk_fuse_open: assert property (!lk |-> o_debug_fuse_wr_ok)
    else $error("fuse write blocked");
  chk_fuse_shut: assert property (lk && !i_chip_erased |-> !o_debug_fuse_wr_ok)
    else $error("fuse write open while locked");
  chk_dis_cause: assert property (!$stable(o_port_disable) |-> $past(ctl))
    else $error("disable bit moved unasked");
  chk_dis_value: assert property (!$stable(o_port_disable) |-> o_port_disable == $past(wb))
    else $error("disable bit wrong value");
  chk_debug_code: assert property (o_debug_sel |-> o_instr[3:2] == 2'b10)
    else $error("debug path on plain code");
  cover property (wr ##2 rd);
  cover property ($rose(o_port_disable));
  cover property (o_debug_sel);
endmodule

bind dmj_debug_port dmj_checker i_dmj_checker (.i_mclk, .i_rst, .i_ce, .i_cpu, .i_fuse,
  .i_chip_erased, .o_cpu_rdata, .o_std_io_sel, .o_port_disable, .o_debug_fuse_wr_ok,
  .o_instr, .o_debug_sel);

// ### verif/dmj_debug_port_tb.sv
`timescale 1ns/1ps
module dmj_debug_port_tb;
  import dmj_pkg::*;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
  logic i_mclk, i_rst, i_ce, i_chip_erased, i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe_n, s;
  logic o_std_io_sel, o_port_disable, o_prog_active, o_debug_fuse_wr_ok, o_debug_sel;
  logic [7:0] i_std_io_rdata, o_cpu_rdata, q, d;
  logic [3:0] o_instr;
  logic [8:0] c;
  dmj_cpu_req_s i_cpu;
  dmj_fuse_s i_fuse;
  int fails = 0, n_tests = 0, seed = 67555;
  dmj_debug_port i_dmj_debug_port (.i_mclk, .i_rst, .i_ce, .i_cpu, .i_fuse, .i_std_io_rdata,
    .i_chip_erased, .o_cpu_rdata, .o_std_io_sel, .o_port_disable, .o_prog_active,
    .o_debug_fuse_wr_ok, .i_tck, .i_tms, .i_tdi, .o_tdo, .o_tdo_oe_n, .o_instr, .o_debug_sel);
  dmj_jtag_host i_dmj_jtag_host (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi), .i_tdo(o_tdo),
    .i_tdo_oe_n(o_tdo_oe_n));
  initial
  begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  function automatic logic [7:0] exp_rd(logic f, logic [7:0] v);
    return {f, v[6:0]};
  endfunction
  task automatic acc(logic w, logic e, logic [5:0] a, logic [7:0] v);
    @(posedge i_mclk);
    i_cpu <= '{rd: !w, wr: w, addr: a, wdata: v};
    i_ce <= e;
    #1 s = o_std_io_sel;
    @(posedge i_mclk);
    i_cpu <= '0;
    i_ce <= 1'b1;
    #1 q = o_cpu_rdata;
  endtask
  // tck domain needs edges while reset is high
  task automatic rst_run();
    i_rst <= 1'b1;
    fork
      repeat (8) @(posedge i_mclk);
      i_dmj_jtag_host.step(1'b1, 1'b1);
    join
    i_rst <= 1'b0;
    i_dmj_jtag_host.park();
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    fails++;
    summarize();
  end
  initial
  begin
    {i_ce, i_chip_erased, i_cpu, i_fuse, i_std_io_rdata} = {2'b10, 16'h0000, 4'hc, 8'h5a};
    rst_run();
    acc(1'b0, 1'b1, DMJ_CTRL_IO_ADDR, 8'h00);
    `CHK(q, DMJ_CTRL_RESET)
    for (int i = 8; i < 12; i++)
    begin
      i_dmj_jtag_host.scan(1'b1, 9'(i), c);
      `CHK({c[3:0], o_instr, o_debug_sel}, {DMJ_IR_CAPTURE, 4'(i), 1'b1})
    end
    $display("test instructions done");
    acc(1'b0, 1'b1, DMJ_COMM_IO_ADDR, 8'h00);
    `CHK({s, q}, {1'b1, i_std_io_rdata})
    i_dmj_jtag_host.scan(1'b0, 9'h001, c);
    acc(1'b0, 1'b1, DMJ_COMM_IO_ADDR, 8'h00);
    `CHK({s, q}, {1'b0, DMJ_COMM_RESET})
    repeat (4)
    begin
      d = 8'($random(seed));
      acc(1'b1, 1'b1, DMJ_COMM_IO_ADDR, d);
      acc(1'b0, 1'b1, DMJ_COMM_IO_ADDR, 8'h00);
      `CHK(q, exp_rd(1'b1, d))
      acc(1'b1, 1'b0, DMJ_COMM_IO_ADDR, ~d);
      acc(1'b0, 1'b1, DMJ_COMM_IO_ADDR, 8'h00);
      `CHK(q, exp_rd(1'b1, d))
    end
    i_dmj_jtag_host.scan(1'b0, 9'h101, c);
    `CHK(c, {1'b1, d})
    acc(1'b0, 1'b1, DMJ_COMM_IO_ADDR, 8'h00);
    `CHK(q, exp_rd(1'b0, d))
    $display("test mailbox done");
    for (int i = 0; i < 16; i++)
    begin
      @(posedge i_mclk);
      i_fuse <= {1'b1, !i[3], i[1:0]};
      i_chip_erased <= i[2];
      acc(1'b0, 1'b1, DMJ_COMM_IO_ADDR, 8'h00);
      `CHK({s, o_debug_fuse_wr_ok}, {i[1:0] != 0 || i[3], i[1:0] == 0 || i[2]})
    end
    i_fuse <= 4'hc;
    $display("test fuses done");
    // disable bit only moved with no debug session running
    i_dmj_jtag_host.park();
    for (int k = 0; k < 4; k++)
    begin
      repeat (8) @(posedge i_mclk);
      acc(1'b1, 1'b1, DMJ_CTRL_IO_ADDR, k == 0 ? 8'h80 : 8'h00);
      repeat (k == 1 ? 8 : 0) @(posedge i_mclk);
      acc(1'b1, 1'b1, DMJ_CTRL_IO_ADDR, k[0] ? 8'h00 : 8'h80);
      `CHK(o_port_disable, k != 3)
      if (k == 0)
      begin
        i_dmj_jtag_host.scan(1'b1, 9'(DMJ_INSTR_A), c);
        `CHK(o_instr, DMJ_IR_RESET)
      end
    end
    i_dmj_jtag_host.park();
    i_dmj_jtag_host.scan(1'b1, 9'(DMJ_INSTR_PROG), c);
    repeat (6) @(posedge i_mclk);
    `CHK({o_instr, o_prog_active}, {DMJ_INSTR_PROG, 1'b1})
    $display("test port done");
    i_dmj_jtag_host.scan(1'b1, 9'(DMJ_INSTR_A), c);
    i_dmj_jtag_host.scan(1'b0, 9'h001, c);
    acc(1'b1, 1'b1, DMJ_COMM_IO_ADDR, 8'hff);
    rst_run();
    i_dmj_jtag_host.scan(1'b1, 9'(DMJ_INSTR_A), c);
    i_dmj_jtag_host.scan(1'b0, 9'h000, c);
    `CHK(c, {1'b0, DMJ_COMM_RESET})
    $display("test second reset done");
    summarize();
  end
endmodule

// ### verif/dmj_jtag_host.sv
`timescale 1ns/1ps
module dmj_jtag_host
  import dmj_pkg::*;
(
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe_n
);
  logic t;
  // tdo has no pull; a released line reads inverted so a late enable shows up
  wire logic tdo_line = i_tdo_oe_n ? ~i_tdo : i_tdo;
  // tck stands still between frames; tdi rests at pull-up level
  initial {o_tck, o_tms, o_tdi} = 3'b011;
  task automatic step(input logic ms, input logic di);
    o_tms = ms;
    o_tdi = di;
    #12 o_tck = 1'b1;
    // tdo is launched on the rising edge, so it is read just before the fall
    #24 t = tdo_line;
    o_tck = 1'b0;
    #12;
  endtask
  task automatic park();
    #3.3;
    repeat (5) step(1'b1, 1'b1);
  endtask
  task automatic scan(input logic ir, input logic [8:0] din, output logic [8:0] q);
    int n;
    n = ir ? DMJ_IR_W : DMJ_DR_W;
    q = '0;
    #3.3;
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    if (ir) step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    // lsb first, tms high on last bit
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i]);
      q[i] = t;
    end
    // dr update carries the dirty clear
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask
endmodule
